//--- rtl/adcss_pkg.sv
package adcss_pkg;
    localparam int ADCSS_DATA_W = 14;
    localparam int ADCSS_CH_N = 8;
    localparam int ADCSS_CH_W = 3;
    localparam int ADCSS_INT_W = 24;
    localparam int ADCSS_DLY_W = 16;

    localparam logic [7:0] ADCSS_REG_CTRL = 8'h00;
    localparam logic [7:0] ADCSS_REG_CHEN = 8'h04;
    localparam logic [7:0] ADCSS_REG_SCAN_IVL = 8'h08;
    localparam logic [7:0] ADCSS_REG_SAMP_IVL = 8'h0C;
    localparam logic [7:0] ADCSS_REG_SCANS = 8'h10;
    localparam logic [7:0] ADCSS_REG_DELAY = 8'h14;
    localparam logic [7:0] ADCSS_REG_CMD = 8'h18;
    localparam logic [7:0] ADCSS_REG_STATUS = 8'h1C;
    localparam logic [7:0] ADCSS_REG_DATA = 8'h20;
    localparam logic [7:0] ADCSS_REG_IRQ_STAT = 8'h24;
    localparam logic [7:0] ADCSS_REG_IRQ_EN = 8'h28;
    localparam logic [7:0] ADCSS_REG_IRQ_CLR = 8'h2C;

    // Control register fields
    localparam int ADCSS_CTRL_MODE = 0;
    localparam int ADCSS_CTRL_DELAY = 1;
    localparam int ADCSS_CTRL_RETRIG = 2;
    localparam int ADCSS_CTRL_TSRC = 3;
    localparam int ADCSS_CTRL_DSRC = 5;
    localparam int ADCSS_CTRL_POL = 7;
    localparam int ADCSS_CTRL_W = 8;
    // Command register bits
    localparam int ADCSS_CMD_CONV = 0;
    localparam int ADCSS_CMD_TRIG = 1;
    localparam int ADCSS_CMD_ARM = 2;
    localparam int ADCSS_CMD_STOP = 3;
    // Interrupt events
    localparam int ADCSS_EV_DONE = 0;
    localparam int ADCSS_EV_SET = 1;
    localparam int ADCSS_EV_OVF = 2;
    localparam int ADCSS_EV_N = 3;

    localparam logic [13:0] ADCSS_UNI_OFFSET = 14'h2000;
    localparam logic [23:0] ADCSS_INT_RESET = 24'h000028;
    localparam logic [23:0] ADCSS_SCANS_RESET = 24'h000001;

    typedef enum logic [1:0] {ADCSS_TS_SOFT, ADCSS_TS_DIG, ADCSS_TS_ANA, ADCSS_TS_SYNC} adcss_tsrc_t;
    typedef enum logic [1:0] {ADCSS_DS_TB, ADCSS_DS_AUX1, ADCSS_DS_TMR0, ADCSS_DS_TMR1} adcss_dsrc_t;

    typedef struct packed {
        // First member is the msb, so the fields run from bit 7 down to bit 0
        logic unipolar;
        adcss_dsrc_t dsrc;
        adcss_tsrc_t tsrc;
        logic retrig;
        logic delay_mode;
        logic polling;
    } adcss_ctrl_t;

    typedef struct packed {
        logic [ADCSS_CH_W-1:0] chan;
        logic [ADCSS_DATA_W-1:0] code;
    } adcss_sample_t;

    // Lowest enabled channel at or above start; returns found flag in msb
    function automatic logic [ADCSS_CH_W:0] adcss_next_chan(input logic [ADCSS_CH_N-1:0] en,
                                                           input logic [ADCSS_CH_W:0] start);
        logic [ADCSS_CH_W:0] r;
        r = '0;
        for (int i = ADCSS_CH_N - 1; i >= 0; i--) begin
            if (en[i] && (i >= int'(start))) begin
                r = {1'b1, ADCSS_CH_W'(i)};
            end
        end
        return r;
    endfunction
endpackage

//--- rtl/adcss_tick.sv
`timescale 1ns/1ps
// Timebase enable divider plus rising-edge detect of the selected delay clock
module adcss_tick
    import adcss_pkg::*;
#(
    parameter int DIV = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic aux_input_1,
    input wire logic timer0_out,
    input wire logic timer1_out,
    input wire adcss_dsrc_t dsrc,
    output logic tb_tick,
    output logic delay_tick
);
    initial begin
        if (DIV < 1) $error("adcss_tick: DIV must be at least 1");
    end

    logic [15:0] div_cnt;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sel_now;
    logic sel_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
            tb_tick <= 1'b0;
        end else if (div_cnt == 16'(DIV - 1)) begin
            div_cnt <= '0;
            tb_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            tb_tick <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {timer1_out, timer0_out, aux_input_1};
            sync2 <= sync1;
        end
    end

    always_comb begin
        case (dsrc)
            ADCSS_DS_AUX1: sel_now = sync2[0];
            ADCSS_DS_TMR0: sel_now = sync2[1];
            ADCSS_DS_TMR1: sel_now = sync2[2];
            default: sel_now = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_prev <= 1'b0;
        end else begin
            sel_prev <= sel_now;
        end
    end

    assign delay_tick = (dsrc == ADCSS_DS_TB) ? tb_tick : (sel_now & ~sel_prev);
endmodule

//--- rtl/adcss_apb.sv
`timescale 1ns/1ps
// Zero-wait APB slave front end: one-cycle write/read strobes
module adcss_apb (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    output logic pready,
    output logic pslverr,
    input wire logic mapped,
    output logic wr_stb,
    output logic rd_stb,
    output logic [7:0] addr
);
    assign pready = 1'b1;
    assign wr_stb = psel & penable & pwrite;
    assign rd_stb = psel & penable & ~pwrite;
    assign pslverr = psel & penable & ~mapped;
    assign addr = {paddr[7:2], 2'b00};
endmodule

//--- rtl/adcss_seq.sv
`timescale 1ns/1ps
module adcss_seq
    import adcss_pkg::*;
#(
    parameter int TB_DIV = 2,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dig_trigger,
    input wire logic ana_trigger,
    input wire logic sync_bus_adc_trigger,
    input wire logic aux_input_1,
    input wire logic timer0_out,
    input wire logic timer1_out,
    output logic conv_start,
    output logic [ADCSS_CH_W-1:0] conv_chan,
    input wire logic conv_done,
    input wire logic [ADCSS_DATA_W-1:0] conv_code,
    output logic irq
);
    initial begin
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) $error("FIFO_DEPTH must be a power of two");
    end
    localparam int AW = $clog2(FIFO_DEPTH);

    typedef enum {S_IDLE, S_ARMED, S_DELAY, S_SCANWAIT, S_CONV, S_GAP} adcss_state_t;
    adcss_state_t state;

    adcss_ctrl_t ctrl;
    logic [ADCSS_CH_N-1:0] chen;
    logic [ADCSS_INT_W-1:0] scan_ivl, samp_ivl, scans;
    logic [ADCSS_DLY_W-1:0] delay;
    logic [ADCSS_INT_W-1:0] scan_timer, samp_timer, scans_per_trigger_count;
    logic [ADCSS_DLY_W-1:0] delay_count;
    logic [ADCSS_CH_W-1:0] chan;
    logic poll_busy, poll_ready, accepted_once;
    logic [ADCSS_DATA_W-1:0] poll_data;
    logic [ADCSS_EV_N-1:0] irq_stat, irq_en, ev;

    logic wr_stb, rd_stb, mapped;
    logic [7:0] addr;
    logic [31:0] wd;
    logic tb_tick, delay_tick;
    logic [2:0] trig_s1, trig_s2;
    logic trig_lvl, trig_prev, sw_trig, trig_event;
    logic cmd_conv, cmd_arm, cmd_stop;
    logic [ADCSS_CH_W:0] first_ch, nxt_ch;
    logic [ADCSS_DATA_W-1:0] code_out;
    logic samp_push;
    adcss_sample_t fifo_mem [FIFO_DEPTH];
    logic [AW:0] wr_ptr, rd_ptr;
    logic fifo_full, fifo_empty, fifo_pop;

    assign wd = pwdata;

    adcss_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .mapped(mapped),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .addr(addr)
    );

    adcss_tick #(.DIV(TB_DIV)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .aux_input_1(aux_input_1),
        .timer0_out(timer0_out),
        .timer1_out(timer1_out),
        .dsrc(ctrl.dsrc),
        .tb_tick(tb_tick),
        .delay_tick(delay_tick)
    );

    always_comb begin
        case (addr)
            ADCSS_REG_CTRL, ADCSS_REG_CHEN, ADCSS_REG_SCAN_IVL, ADCSS_REG_SAMP_IVL, ADCSS_REG_SCANS,
            ADCSS_REG_DELAY, ADCSS_REG_CMD, ADCSS_REG_STATUS, ADCSS_REG_DATA, ADCSS_REG_IRQ_STAT,
            ADCSS_REG_IRQ_EN, ADCSS_REG_IRQ_CLR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign cmd_conv = wr_stb && addr == ADCSS_REG_CMD && wd[ADCSS_CMD_CONV];
    assign cmd_arm = wr_stb && addr == ADCSS_REG_CMD && wd[ADCSS_CMD_ARM];
    assign cmd_stop = wr_stb && addr == ADCSS_REG_CMD && wd[ADCSS_CMD_STOP];
    assign sw_trig = wr_stb && addr == ADCSS_REG_CMD && wd[ADCSS_CMD_TRIG];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
            chen <= '0;
            scan_ivl <= ADCSS_INT_RESET;
            samp_ivl <= ADCSS_INT_RESET;
            scans <= ADCSS_SCANS_RESET;
            delay <= '0;
            irq_en <= '0;
        end else if (wr_stb) begin
            case (addr)
                ADCSS_REG_CTRL: ctrl <= wd[ADCSS_CTRL_W-1:0];
                ADCSS_REG_CHEN: chen <= wd[ADCSS_CH_N-1:0];
                ADCSS_REG_SCAN_IVL: scan_ivl <= wd[ADCSS_INT_W-1:0];
                ADCSS_REG_SAMP_IVL: samp_ivl <= wd[ADCSS_INT_W-1:0];
                ADCSS_REG_SCANS: scans <= wd[ADCSS_INT_W-1:0];
                ADCSS_REG_DELAY: delay <= wd[ADCSS_DLY_W-1:0];
                ADCSS_REG_IRQ_EN: irq_en <= wd[ADCSS_EV_N-1:0];
                default: ;
            endcase
        end
    end

    // Pins are from outside the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s1 <= '0;
            trig_s2 <= '0;
            trig_prev <= 1'b0;
        end else begin
            trig_s1 <= {sync_bus_adc_trigger, ana_trigger, dig_trigger};
            trig_s2 <= trig_s1;
            trig_prev <= trig_lvl;
        end
    end

    always_comb begin
        case (ctrl.tsrc)
            ADCSS_TS_DIG: trig_lvl = trig_s2[0];
            ADCSS_TS_ANA: trig_lvl = trig_s2[1];
            ADCSS_TS_SYNC: trig_lvl = trig_s2[2];
            default: trig_lvl = 1'b0;
        endcase
    end

    // Rising edge of the selected source, or the software command
    assign trig_event = (ctrl.tsrc == ADCSS_TS_SOFT) ? sw_trig : (trig_lvl & ~trig_prev);

    assign first_ch = adcss_next_chan(chen, '0);
    assign nxt_ch = adcss_next_chan(chen, {1'b0, chan} + 4'(1));

    // Unipolar ranges shift the straight offset code into the same code set
    assign code_out = ctrl.unipolar ? (conv_code ^ ADCSS_UNI_OFFSET) : conv_code;

    assign samp_push = conv_done && !fifo_full && (state == S_CONV);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            scan_timer <= '0;
            samp_timer <= '0;
            scans_per_trigger_count <= '0;
            delay_count <= '0;
            chan <= '0;
            accepted_once <= 1'b0;
        end else if (cmd_stop) begin
            state <= S_IDLE;
        end else begin
            if (state != S_IDLE && scan_timer != '0 && tb_tick) begin
                scan_timer <= scan_timer - 24'h000001;
            end
            case (state)
                S_IDLE: begin
                    if (cmd_arm && !ctrl.polling && first_ch[ADCSS_CH_W]) begin
                        state <= S_ARMED;
                        accepted_once <= 1'b0;
                    end
                end
                S_ARMED: begin
                    // A trigger is taken only here, never mid-scan
                    if (trig_event && !(accepted_once && !ctrl.retrig)) begin
                        accepted_once <= 1'b1;
                        delay_count <= delay;
                        scans_per_trigger_count <= scans;
                        scan_timer <= '0;
                        state <= ctrl.delay_mode ? S_DELAY : S_SCANWAIT;
                    end else if (accepted_once && !ctrl.retrig) begin
                        state <= S_IDLE;
                    end
                end
                S_DELAY: begin
                    if (delay_count == '0) begin
                        state <= S_SCANWAIT;
                    end else if (delay_tick) begin
                        delay_count <= delay_count - 16'h0001;
                    end
                end
                S_SCANWAIT: begin
                    if (scans_per_trigger_count == '0) begin
                        state <= ctrl.retrig ? S_ARMED : S_IDLE;
                    end else if (scan_timer == '0 && tb_tick) begin
                        // Start on a timebase edge and count it, so the interval is exact
                        scan_timer <= (scan_ivl == '0) ? '0 : scan_ivl - 24'h000001;
                        scans_per_trigger_count <= scans_per_trigger_count - 24'h000001;
                        chan <= first_ch[ADCSS_CH_W-1:0];
                        state <= S_CONV;
                    end
                end
                S_CONV: begin
                    // A sample dropped on a full queue still moves the scan on
                    if (conv_done) begin
                        if (nxt_ch[ADCSS_CH_W]) begin
                            chan <= nxt_ch[ADCSS_CH_W-1:0];
                            samp_timer <= samp_ivl;
                            state <= S_GAP;
                        end else begin
                            state <= S_SCANWAIT;
                        end
                    end
                end
                S_GAP: begin
                    if (samp_timer <= 24'h000001) begin
                        state <= S_CONV;
                    end else if (tb_tick) begin
                        samp_timer <= samp_timer - 24'h000001;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // One conversion request per sample slot or per polling command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_start <= 1'b0;
            conv_chan <= '0;
        end else begin
            conv_start <= 1'b0;
            if (cmd_conv && ctrl.polling && !poll_busy && state == S_IDLE) begin
                conv_start <= 1'b1;
                conv_chan <= first_ch[ADCSS_CH_W-1:0];
            end else if ((state == S_SCANWAIT && scan_timer == '0 && tb_tick && scans_per_trigger_count != '0)
                         || (state == S_GAP && samp_timer <= 24'h000001)) begin
                conv_start <= 1'b1;
                conv_chan <= (state == S_GAP) ? chan : first_ch[ADCSS_CH_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poll_busy <= 1'b0;
            poll_ready <= 1'b0;
            poll_data <= '0;
        end else begin
            if (cmd_conv && ctrl.polling && !poll_busy && state == S_IDLE) begin
                poll_busy <= 1'b1;
            end else if (poll_busy && conv_done) begin
                poll_busy <= 1'b0;
                poll_data <= code_out;
            end
            // Completion beats the read that clears it
            if (poll_busy && conv_done) begin
                poll_ready <= 1'b1;
            end else if (rd_stb && addr == ADCSS_REG_DATA) begin
                poll_ready <= 1'b0;
            end
        end
    end

    assign fifo_full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign fifo_empty = wr_ptr == rd_ptr;
    assign fifo_pop = rd_stb && addr == ADCSS_REG_DATA && !ctrl.polling && !fifo_empty;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (samp_push) begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (fifo_pop) begin
                rd_ptr <= rd_ptr + (AW+1)'(1);
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (samp_push) begin
            fifo_mem[wr_ptr[AW-1:0]] <= '{chan: chan, code: code_out};
        end
    end

    assign ev[ADCSS_EV_DONE] = poll_busy && conv_done;
    assign ev[ADCSS_EV_SET] = state == S_SCANWAIT && scans_per_trigger_count == '0;
    assign ev[ADCSS_EV_OVF] = conv_done && fifo_full && state == S_CONV;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= ev | (irq_stat & ~((wr_stb && addr == ADCSS_REG_IRQ_CLR) ? wd[ADCSS_EV_N-1:0] : '0));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_en);
        end
    end

    always_comb begin
        prdata = '0;
        case (addr)
            ADCSS_REG_CTRL: prdata[ADCSS_CTRL_W-1:0] = ctrl;
            ADCSS_REG_CHEN: prdata[ADCSS_CH_N-1:0] = chen;
            ADCSS_REG_SCAN_IVL: prdata[ADCSS_INT_W-1:0] = scan_ivl;
            ADCSS_REG_SAMP_IVL: prdata[ADCSS_INT_W-1:0] = samp_ivl;
            ADCSS_REG_SCANS: prdata[ADCSS_INT_W-1:0] = scans;
            ADCSS_REG_DELAY: prdata[ADCSS_DLY_W-1:0] = delay;
            ADCSS_REG_STATUS: prdata[7:0] = {fifo_full, !fifo_empty, poll_ready, poll_busy,
                                             1'b0, 3'(state)};
            ADCSS_REG_DATA: prdata[16:0] = ctrl.polling ? {3'b000, poll_data}
                                                         : fifo_mem[rd_ptr[AW-1:0]];
            ADCSS_REG_IRQ_STAT: prdata[ADCSS_EV_N-1:0] = irq_stat;
            ADCSS_REG_IRQ_EN: prdata[ADCSS_EV_N-1:0] = irq_en;
            default: prdata = '0;
        endcase
    end
endmodule

//--- tb/adcss_seq_properties.sv
`timescale 1ns/1ps
module adcss_seq_properties
    import adcss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic conv_start,
    input wire logic [ADCSS_CH_W-1:0] conv_chan,
    input wire logic conv_done,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] ctrl_sh;
    logic [7:0] chen_sh;
    logic [ADCSS_EV_N-1:0] en_sh;
    logic acc;
    logic wr;
    logic bad;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign bad = {paddr[7:2], 2'b00} > ADCSS_REG_IRQ_CLR;
    // Shadows of the setup, rebuilt from the bus since the checker sees no internals
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_sh <= '0;
            chen_sh <= '0;
            en_sh <= '0;
        end else if (wr) begin
            if (paddr == ADCSS_REG_CTRL) ctrl_sh <= pwdata[7:0];
            if (paddr == ADCSS_REG_CHEN) chen_sh <= pwdata[7:0];
            if (paddr == ADCSS_REG_IRQ_EN) en_sh <= pwdata[ADCSS_EV_N-1:0];
        end
    end
    a_ready_always: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (acc && bad |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_err_mapped: assert property (acc && !bad |-> !pslverr) else $error("mapped access refused");
    a_err_idle: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
    a_start_pulse: assert property (conv_start |=> !conv_start) else $error("start not a pulse");
    a_start_waits: assert property (conv_start |=> !conv_start until conv_done) else $error("start before done");
    a_chan_enabled: assert property (conv_start && !ctrl_sh[ADCSS_CTRL_MODE] |-> chen_sh[conv_chan])
        else $error("disabled channel sampled");
    a_poll_start: assert property (wr && paddr == ADCSS_REG_CMD && pwdata[ADCSS_CMD_CONV]
        && ctrl_sh[ADCSS_CTRL_MODE] |-> ##[1:4] conv_start) else $error("poll command lost");
    a_irq_masked: assert property (!$past(|en_sh) |-> !irq) else $error("irq while masked");
    c_poll: cover property (wr && paddr == ADCSS_REG_CMD && pwdata[ADCSS_CMD_CONV]);
    c_scan: cover property (conv_start && !ctrl_sh[ADCSS_CTRL_MODE]);
    c_irq: cover property ($rose(irq));
endmodule

//--- tb/adcss_conv_model.sv
`timescale 1ns/1ps
module adcss_conv_model
    import adcss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_start,
    input wire logic [ADCSS_DATA_W-1:0] base,
    input wire logic [3:0] lat,
    output logic conv_done,
    output logic [ADCSS_DATA_W-1:0] conv_code
);
    logic [3:0] cnt;
    // Code flips every idle cycle so a late capture cannot pass by luck
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            conv_done <= 1'h0;
            conv_code <= '0;
        end else begin
            conv_done <= 1'h0;
            conv_code <= ~conv_code;
            if (conv_start) cnt <= lat;
            else if (cnt == 4'h1) begin
                conv_done <= 1'h1;
                conv_code <= base;
                cnt <= '0;
            end else if (cnt != 4'h0) cnt <= cnt - 4'h1;
        end
    end
endmodule

//--- tb/tb_adcss_seq.sv
`timescale 1ns/1ps
module tb_adcss_seq;
    import adcss_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, conv_start, conv_done, irq;
    logic [5:0] pins = '0;
    logic [ADCSS_CH_W-1:0] conv_chan, chans[$];
    logic [ADCSS_CH_W-1:0] ord[3] = '{3'h1, 3'h2, 3'h4};
    logic [ADCSS_DATA_W-1:0] conv_code, base = '0;
    logic [3:0] lat = 4'h5;
    int error_cnt = 0, n_compared = 0, n_starts = 0, cyc = 0, st_cyc[$];
    adcss_seq #(.TB_DIV(2), .FIFO_DEPTH(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dig_trigger(pins[0]), .ana_trigger(pins[1]),
        .sync_bus_adc_trigger(pins[2]), .aux_input_1(pins[3]), .timer0_out(pins[4]),
        .timer1_out(pins[5]), .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_done(conv_done), .conv_code(conv_code), .irq(irq));
    adcss_conv_model u_conv (.pclk(pclk), .presetn(presetn), .conv_start(conv_start), .base(base),
        .lat(lat), .conv_done(conv_done), .conv_code(conv_code));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (conv_start === 1'h1) begin
            n_starts++;
            chans.push_back(conv_chan);
            st_cyc.push_back(cyc);
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic pulse(input int i);
        pins[i] <= 1'h1;
        repeat (6) @(posedge pclk);
        pins[i] <= 1'h0;
        repeat (6) @(posedge pclk);
    endtask
    task automatic wait_n(input int n);
        for (int k = 0; k < 500 && n_starts < n; k++) @(posedge pclk);
    endtask
    function automatic logic [31:0] cw(logic p, logic d, logic r, logic [1:0] ts, logic [1:0] ds, logic u);
        return 32'(p) << ADCSS_CTRL_MODE | 32'(d) << ADCSS_CTRL_DELAY | 32'(r) << ADCSS_CTRL_RETRIG
            | 32'(ts) << ADCSS_CTRL_TSRC | 32'(ds) << ADCSS_CTRL_DSRC | 32'(u) << ADCSS_CTRL_POL;
    endfunction
    task automatic t_regs();
        apb(1'h0, ADCSS_REG_SCAN_IVL, '0);
        check(rd, 32'(ADCSS_INT_RESET));
        apb(1'h0, ADCSS_REG_SCANS, '0);
        check(rd, 32'(ADCSS_SCANS_RESET));
        apb(1'h0, 8'h30, '0);
        check({rd[30:0], err}, 32'h1);
        $display("t_regs done");
    endtask
    task automatic t_poll();
        int k;
        base = 14'h1FFF;
        apb(1'h1, ADCSS_REG_IRQ_EN, 32'h1);
        for (int u = 0; u < 2; u++) begin
            apb(1'h1, ADCSS_REG_CTRL, cw(1'h1, 1'h0, 1'h0, 2'h0, 2'h0, u[0]));
            apb(1'h1, ADCSS_REG_CMD, 32'h1 << ADCSS_CMD_CONV);
            k = 0;
            do begin
                apb(1'h0, ADCSS_REG_STATUS, '0);
                k++;
            end while (rd[5] !== 1'h1 && k < 50);
            apb(1'h0, ADCSS_REG_DATA, '0);
            check(32'(rd[13:0]), u ? 32'h3FFF : 32'h1FFF);
            apb(1'h0, ADCSS_REG_STATUS, '0);
            check(32'(rd[5]), 32'h0);
        end
        check(32'(irq), 32'h1);
        apb(1'h1, ADCSS_REG_IRQ_EN, 32'h0);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0);
        apb(1'h1, ADCSS_REG_IRQ_EN, 32'h1);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h1);
        apb(1'h1, ADCSS_REG_IRQ_CLR, 32'h1);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0);
        apb(1'h0, ADCSS_REG_IRQ_STAT, '0);
        check(rd & 32'h1, 32'h0);
        $display("t_poll done");
    endtask
    task automatic t_scan();
        int b;
        b = n_starts;
        base = 14'h2000;
        apb(1'h1, ADCSS_REG_CTRL, cw(1'h0, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0));
        apb(1'h1, ADCSS_REG_CHEN, 32'h16);
        apb(1'h1, ADCSS_REG_SCANS, 32'h2);
        apb(1'h1, ADCSS_REG_SCAN_IVL, 32'h20);
        apb(1'h1, ADCSS_REG_SAMP_IVL, 32'h4);
        apb(1'h1, ADCSS_REG_CMD, 32'h1 << ADCSS_CMD_ARM);
        apb(1'h1, ADCSS_REG_CMD, 32'h1 << ADCSS_CMD_TRIG);
        wait_n(b + 2);
        apb(1'h1, ADCSS_REG_CMD, 32'h1 << ADCSS_CMD_TRIG);
        wait_n(b + 6);
        repeat (100) @(posedge pclk);
        apb(1'h1, ADCSS_REG_CMD, 32'h1 << ADCSS_CMD_TRIG);
        repeat (200) @(posedge pclk);
        check(n_starts - b, 6);
        for (int i = 0; i < 6; i++) begin
            check(32'(chans[b+i]), 32'(ord[i%3]));
            apb(1'h0, ADCSS_REG_DATA, '0);
            check(32'(rd[16:0]), {15'h0, ord[i%3], 14'h2000});
        end
        check(st_cyc[b+3] - st_cyc[b], 64);
        $display("t_scan done");
    endtask
    task automatic t_trig();
        int b;
        lat = 4'h1;
        apb(1'h1, ADCSS_REG_CHEN, 32'h1);
        apb(1'h1, ADCSS_REG_SCANS, 32'h1);
        apb(1'h1, ADCSS_REG_DELAY, 32'h2);
        for (int i = 0; i < 3; i++) begin
            apb(1'h1, ADCSS_REG_CMD, 32'h1 << ADCSS_CMD_STOP);
            apb(1'h1, ADCSS_REG_CTRL, cw(1'h0, 1'h1, 1'h1, 2'(i + 1), 2'(i + 1), 1'h0));
            apb(1'h1, ADCSS_REG_CMD, 32'h1 << ADCSS_CMD_ARM);
            b = n_starts;
            pulse((i + 1) % 3);
            pulse(i + 3);
            pulse(i + 3);
            check(n_starts - b, 0);
            for (int r = 0; r < 2; r++) begin
                pulse(i);
                pulse(i + 3);
                check(n_starts - b, r);
                pulse(i + 3);
                wait_n(b + r + 1);
                check(n_starts - b, r + 1);
                // Let the sample land in the queue before popping it
                repeat (4) @(posedge pclk);
                apb(1'h0, ADCSS_REG_DATA, '0);
                check(32'(rd[16:0]), {15'h0, 3'h0, base});
            end
        end
        $display("t_trig done");
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs();
        t_poll();
        t_scan();
        t_trig();
        complete_run();
    end
endmodule
bind adcss_seq adcss_seq_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_done(conv_done), .irq(irq));
